// >>> hdl/supervisor_pkg.sv
package supervisor_pkg;

  // ==========================================================
  // geometry
  localparam int CHANNELS      = 5;
  localparam int DIRECT_INPUTS = 4;
  localparam int FRAME_MOD     = 16;
  localparam int FAULT_KINDS   = 8;

  // ==========================================================
  // timing
  localparam int CLK_MHZ       = 200;
  localparam int DEGLITCH_US   = 200;
  localparam int DEGLITCH_CYC  = DEGLITCH_US * CLK_MHZ;
  localparam int WD_TIMEOUT_MS = 32;
  localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_MS * 1000 * CLK_MHZ;

  // ==========================================================
  // status register #7 layout
  localparam int STATUS_REG_INDEX = 7;
  localparam int STATUS_W         = 8;
  localparam int SERIAL_FAIL_BIT  = 0;
  localparam int FAIL_REQ_BIT     = 1;
  localparam int FAIL_MODE_BIT    = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ==========================================================
  // modes
  typedef enum logic [1:0] {
    MODE_POWER_OFF = 2'b00,
    MODE_NORMAL    = 2'b01,
    MODE_FAIL      = 2'b10
  } mode_t;

  // supply and ground monitors
  typedef struct packed {
    logic bat_ok;
    logic logic_ok;
    logic gnd_ok;
  } supply_t;

  // one received serial frame, as seen at chip-select release
  typedef struct packed {
    logic        done;
    logic        toggle_bit;
    logic [15:0] bit_count;
  } frame_t;

  // fault reports: open load, short to battery, severe short to ground,
  // overcurrent, overtemperature, clock fail, undervoltage, overvoltage
  typedef logic [7:0] faults_t;

endpackage

// >>> hdl/supply_loss_fail_mode_supervisor.sv
`timescale 1ns/1ps
`default_nettype none

module supply_loss_fail_mode_supervisor
  import supervisor_pkg::*;
#(
  parameter int DEGLITCH_CYCLES = DEGLITCH_CYC,
  parameter int WD_CYCLES       = WD_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // supply monitors and pins
  input  wire supply_t                  supply_in,
  input  wire logic                     fail_mode_request_input,
  input  wire logic [DIRECT_INPUTS-1:0] direct_channel_inputs,
  input  wire logic                     reset_input_low_active,
  input  wire logic                     wake_state,
  // from pwm engine, serial core, diagnostics
  input  wire logic [CHANNELS-1:0]      pwm_channels,
  input  wire logic                     driver_setting,
  input  wire frame_t                   frame_in,
  input  wire faults_t                  faults_in,
  // outputs
  output logic      [CHANNELS-1:0]      power_channel_outputs,
  output logic                          external_driver_control_output,
  output logic                          clk_pin_out,
  output logic                          clk_pin_oe_n,
  output logic      [STATUS_W-1:0]      status_reg7,
  output var faults_t                   fault_report,
  output var mode_t                     mode
);

  if (DEGLITCH_CYCLES < 1 || WD_CYCLES < 1 || DIRECT_INPUTS > CHANNELS) begin : g_bad_counts
    $error("counts or widths out of range");
  end

  // ==========================================================
  // input synchronisers
  logic [2:0]               sup_s1_r, sup_s2_r;
  logic                     req_s1_r, req_s2_r, reset_input_low_active_s1_r, reset_input_low_active_s2_r;
  logic [DIRECT_INPUTS-1:0] din_s1_r, din_s2_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_s1_r  <= 3'h0;
      sup_s2_r  <= 3'h0;
      req_s1_r  <= 1'b0;
      req_s2_r  <= 1'b0;
      reset_input_low_active_s1_r <= 1'b0;
      reset_input_low_active_s2_r <= 1'b0;
      din_s1_r  <= '0;
      din_s2_r  <= '0;
    end else begin
      sup_s1_r  <= supply_in;
      sup_s2_r  <= sup_s1_r;
      req_s1_r  <= fail_mode_request_input;
      req_s2_r  <= req_s1_r;
      reset_input_low_active_s1_r <= reset_input_low_active;
      reset_input_low_active_s2_r <= reset_input_low_active_s1_r;
      din_s1_r  <= direct_channel_inputs;
      din_s2_r  <= din_s1_r;
    end
  end

  supply_t sup;
  assign sup = supply_t'(sup_s2_r);
  logic both_lost;
  assign both_lost = !sup.bat_ok && !sup.logic_ok;

  // ==========================================================
  // fail request deglitch, symmetric
  logic [31:0] dgl_cnt_r, dgl_cnt_nxt;
  logic        filtered_fail_request_r, filt_nxt;

  always_comb begin
    dgl_cnt_nxt = 32'h0000_0000;
    filt_nxt    = filtered_fail_request_r;
    if (req_s2_r != filtered_fail_request_r) begin
      dgl_cnt_nxt = dgl_cnt_r + 32'h0000_0001;
      if (dgl_cnt_r >= 32'(DEGLITCH_CYCLES - 1)) begin
        filt_nxt    = req_s2_r;
        dgl_cnt_nxt = 32'h0000_0000;
      end
    end
    // losing both supplies wipes the filter as well
    if (both_lost) begin
      filt_nxt    = 1'b0;
      dgl_cnt_nxt = 32'h0000_0000;
    end
  end

  // ==========================================================
  // serial frame checks and watchdog
  logic [31:0] wd_cnt_r, wd_cnt_nxt;
  logic        last_toggle_r, last_toggle_nxt;
  logic        comm_fault;
  logic        frame_good;
  logic        toggle_err, length_err, wd_expired;

  always_comb begin
    toggle_err = frame_in.done && (frame_in.toggle_bit == last_toggle_r);
    length_err = frame_in.done
                 && ((frame_in.bit_count % 16'(FRAME_MOD)) != 16'h0000
                     || frame_in.bit_count == 16'h0000);
    frame_good = frame_in.done && !toggle_err && !length_err;
    wd_expired = (wd_cnt_r >= 32'(WD_CYCLES - 1));
    comm_fault = toggle_err || length_err || wd_expired || !sup.logic_ok;
    last_toggle_nxt = frame_in.done ? frame_in.toggle_bit : last_toggle_r;
    if (frame_good || wd_expired) begin
      wd_cnt_nxt = 32'h0000_0000;
    end else begin
      wd_cnt_nxt = wd_cnt_r + 32'h0000_0001;
    end
    // power off forgets the toggle history, so the first frame after it must carry 1
    if (both_lost) begin
      last_toggle_nxt = 1'b0;
      wd_cnt_nxt      = 32'h0000_0000;
    end
  end

  // ==========================================================
  // mode and serial failure flag
  mode_t mode_nxt;
  logic  serial_failure_flag_r, sff_nxt;
  logic  fail_cause;

  always_comb begin
    fail_cause = filtered_fail_request_r || comm_fault;
    mode_nxt   = mode;
    sff_nxt    = serial_failure_flag_r;
    if (both_lost) begin
      mode_nxt = MODE_POWER_OFF;
      sff_nxt  = 1'b0;
    end else begin
      unique case (mode)
        MODE_POWER_OFF: begin
          mode_nxt = fail_cause ? MODE_FAIL : MODE_NORMAL;
        end
        MODE_NORMAL: begin
          if (fail_cause) begin
            mode_nxt = MODE_FAIL;
          end
        end
        MODE_FAIL: begin
          // leaving needs a good frame, no request and no fault in that same cycle
          if (!fail_cause && frame_good) begin
            mode_nxt = MODE_NORMAL;
            sff_nxt  = 1'b0;
          end
        end
        default: mode_nxt = MODE_POWER_OFF;
      endcase
      if (comm_fault) begin
        sff_nxt = 1'b1;
      end
    end
  end

  // ==========================================================
  // output steering
  logic [CHANNELS-1:0]      chan_nxt;
  logic                     drv_nxt, clk_nxt, clk_oe_n_nxt;
  logic [STATUS_W-1:0]      stat_nxt;
  faults_t                  flt_nxt;
  logic [CHANNELS-1:0]      direct_ext;

  assign direct_ext = {{(CHANNELS-DIRECT_INPUTS){1'b0}}, din_s2_r};

  always_comb begin
    chan_nxt = '0;
    if (mode_nxt == MODE_FAIL) begin
      chan_nxt = direct_ext;
    end else if (mode_nxt == MODE_NORMAL) begin
      chan_nxt = pwm_channels;
    end
    if (!sup.bat_ok || !sup.gnd_ok || both_lost) begin
      chan_nxt = '0;
    end
    // external driver runs from the logic supply, so battery loss leaves it alone
    drv_nxt = (mode_nxt == MODE_NORMAL) && driver_setting;
    clk_nxt = 1'b1;
    clk_oe_n_nxt = !(wake_state && !reset_input_low_active_s2_r && sup.bat_ok);
    stat_nxt = STATUS_RESET;
    stat_nxt[SERIAL_FAIL_BIT] = serial_failure_flag_r;
    stat_nxt[FAIL_REQ_BIT]    = req_s2_r;
    stat_nxt[FAIL_MODE_BIT]   = (mode == MODE_FAIL);
    flt_nxt = both_lost ? '0 : faults_in;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dgl_cnt_r               <= 32'h0000_0000;
      filtered_fail_request_r <= 1'b0;
      wd_cnt_r                <= 32'h0000_0000;
      last_toggle_r           <= 1'b0;
      mode                    <= MODE_POWER_OFF;
      serial_failure_flag_r   <= 1'b0;
      power_channel_outputs   <= '0;
      external_driver_control_output <= 1'b0;
      clk_pin_out             <= 1'b0;
      clk_pin_oe_n            <= 1'b1;
      status_reg7             <= STATUS_RESET;
      fault_report            <= '0;
    end else begin
      dgl_cnt_r               <= dgl_cnt_nxt;
      filtered_fail_request_r <= filt_nxt;
      wd_cnt_r                <= wd_cnt_nxt;
      last_toggle_r           <= last_toggle_nxt;
      mode                    <= mode_nxt;
      serial_failure_flag_r   <= sff_nxt;
      power_channel_outputs   <= chan_nxt;
      external_driver_control_output <= drv_nxt;
      clk_pin_out             <= clk_nxt;
      clk_pin_oe_n            <= clk_oe_n_nxt;
      status_reg7             <= stat_nxt;
      fault_report            <= flt_nxt;
    end
  end

  // ==========================================================
  // checks
  sequence s_fault;
    comm_fault;
  endsequence
  sequence s_flag_set;
    ##1 serial_failure_flag_r ##1 status_reg7[SERIAL_FAIL_BIT];
  endsequence
  sequence s_bad_frame;
    toggle_err || length_err;
  endsequence
  sequence s_enter_fail;
    ##1 (mode == MODE_FAIL) ##1 status_reg7[FAIL_MODE_BIT];
  endsequence

  power_off_clear_a: assert property (@(posedge clk) disable iff (rst)
    both_lost |=> (mode == MODE_POWER_OFF) && !serial_failure_flag_r
                  && power_channel_outputs == '0)
    else $error("power off did not clear state");
  bat_loss_off_a: assert property (@(posedge clk) disable iff (rst)
    !sup.bat_ok |=> power_channel_outputs == '0)
    else $error("channels on without battery");
  gnd_loss_off_a: assert property (@(posedge clk) disable iff (rst)
    !sup.gnd_ok |=> power_channel_outputs == '0)
    else $error("channels on without ground");
  logic_loss_fault_a: assert property (@(posedge clk) disable iff (rst)
    (sup.bat_ok && !sup.logic_ok) |=> mode == MODE_FAIL)
    else $error("logic supply loss did not force fail mode");
  fault_flag_a: assert property (@(posedge clk) disable iff (rst)
    (s_fault and !both_lost) |-> s_flag_set)
    else $error("serial failure flag not reported");
  flag_hold_a: assert property (@(posedge clk) disable iff (rst)
    (mode == MODE_FAIL && mode_nxt == MODE_FAIL && serial_failure_flag_r)
      |=> serial_failure_flag_r)
    else $error("flag dropped in fail mode");
  flag_clear_a: assert property (@(posedge clk) disable iff (rst)
    ($past(mode) == MODE_FAIL && mode == MODE_NORMAL) |-> !serial_failure_flag_r)
    else $error("flag kept after leaving fail mode");
  direct_follow_a: assert property (@(posedge clk) disable iff (rst)
    (mode_nxt == MODE_FAIL && sup.bat_ok && sup.gnd_ok)
      |=> power_channel_outputs == $past(direct_ext))
    else $error("channels not following direct inputs");
  wake_report_a: assert property (@(posedge clk) disable iff (rst)
    !sup.bat_ok |=> clk_pin_oe_n)
    else $error("wake reported without battery");
  status_req_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> status_reg7[FAIL_REQ_BIT] == $past(req_s2_r))
    else $error("request status bit wrong");
  bad_frame_fail_a: assert property (@(posedge clk) disable iff (rst)
    (s_bad_frame and !both_lost) |-> s_enter_fail)
    else $error("bad frame did not force fail mode");
  request_fail_a: assert property (@(posedge clk) disable iff (rst)
    (filtered_fail_request_r && !both_lost) |=> mode == MODE_FAIL)
    else $error("filtered request did not force fail mode");
  filter_stable_a: assert property (@(posedge clk) disable iff (rst)
    (req_s2_r == filtered_fail_request_r && !both_lost) |=> $stable(filtered_fail_request_r))
    else $error("filtered request moved without cause");
  driver_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!sup.bat_ok && sup.logic_ok && mode_nxt == MODE_NORMAL)
      |=> external_driver_control_output == $past(driver_setting))
    else $error("driver output forced during battery loss");

endmodule

`default_nettype wire

// >>> test/host_frame_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_frame_model
  import supervisor_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // commands from the bench
  input  wire logic keep,
  input  wire logic bad_toggle,
  input  wire logic bad_len,
  // frame seen by the device
  output var frame_t frame
);
  logic [3:0] cnt;
  logic       tog;

  // ==========================================================
  // one frame every 16 cycles while keep is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt   <= '0;
      tog   <= 1'b0;
      frame <= '0;
    end else begin
      cnt              <= cnt + 4'h1;
      frame.done       <= 1'b0;
      // idle fields change every cycle so stale values never look valid
      frame.toggle_bit <= ~frame.toggle_bit;
      frame.bit_count  <= ~frame.bit_count;
      if (keep && cnt == 4'hf) begin
        frame.done       <= 1'b1;
        frame.toggle_bit <= bad_toggle ? tog : ~tog;
        frame.bit_count  <= bad_len ? 16'h0011 : 16'h0020;
        if (!bad_toggle) begin
          tog <= ~tog;
        end
      end
    end
  end
endmodule

`default_nettype wire

// >>> test/supply_loss_fail_mode_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none

module supply_loss_fail_mode_supervisor_tb;
  import supervisor_pkg::*;
  logic clk = 0, rst = 1, req = 0, rlow = 1, wake = 0, drv = 0;
  logic keep = 0, bt = 0, bl = 0;
  logic [3:0] din = '0;
  logic [4:0] pwm = '0, pch;
  supply_t sup = 3'b111;
  faults_t flt = '0, frep;
  frame_t frm;
  logic ext, cpo, cpoe;
  logic [7:0] st7;
  mode_t md;
  int fails = 0, num_checks = 0, cyc = 0;

  supply_loss_fail_mode_supervisor #(.DEGLITCH_CYCLES(8), .WD_CYCLES(50))
  i_supply_loss_fail_mode_supervisor (.clk(clk), .rst(rst), .supply_in(sup),
    .fail_mode_request_input(req), .direct_channel_inputs(din),
    .reset_input_low_active(rlow), .wake_state(wake), .pwm_channels(pwm),
    .driver_setting(drv), .frame_in(frm), .faults_in(flt),
    .power_channel_outputs(pch), .external_driver_control_output(ext),
    .clk_pin_out(cpo), .clk_pin_oe_n(cpoe), .status_reg7(st7),
    .fault_report(frep), .mode(md));

  host_frame_model i_host_frame_model (.clk(clk), .rst(rst), .keep(keep),
    .bad_toggle(bt), .bad_len(bl), .frame(frm));

  // ==========================================================
  // helpers
  initial forever #2.5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  function automatic logic [4:0] exp_ch(input mode_t m, input logic [4:0] p,
                                        input logic [3:0] d);
    return (m == MODE_FAIL) ? {1'b0, d} : p;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_md(input mode_t m);
    for (int i = 0; i < 300 && md !== m; i++) run(1);
    chk(md, m, "mode");
  endtask

  // random traffic, outputs judged after sync and deglitch have settled
  task automatic rnd(input mode_t m);
    repeat (12) begin
      @(posedge clk);
      pwm <= 5'($urandom);
      din <= 4'($urandom);
      drv <= 1'($urandom);
      flt <= 8'($urandom);
      run(14);
      chk(pch, exp_ch(m, pwm, din), "channels");
      chk(ext, (m == MODE_NORMAL) ? drv : 1'b0, "driver");
      chk(frep, flt, "faults");
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial begin
    void'($urandom(32'h08a2efa7));
    run(5);
    chk(md, MODE_POWER_OFF, "reset mode");
    @(posedge clk) rst <= 0;
    keep <= 1;
    wait_md(MODE_NORMAL);
    rnd(MODE_NORMAL);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      if (k == 0) bt <= 1;
      else bl <= 1;
      wait_md(MODE_FAIL);
      run(2);
      chk(st7[0], 1'b1, "flag set");
      chk(st7[2], 1'b1, "fail mode bit");
      rnd(MODE_FAIL);
      chk(st7[0], 1'b1, "flag held");
      @(posedge clk) {bt, bl} <= 2'b00;
      wait_md(MODE_NORMAL);
      run(2);
      chk(st7[0], 1'b0, "flag cleared");
    end
    @(posedge clk) keep <= 0;
    wait_md(MODE_FAIL);
    @(posedge clk) keep <= 1;
    wait_md(MODE_NORMAL);
    @(posedge clk) req <= 1;
    run(3);
    @(posedge clk) req <= 0;
    run(20);
    chk(md, MODE_NORMAL, "short request");
    chk(st7[1], 1'b0, "request bit low");
    @(posedge clk) req <= 1;
    wait_md(MODE_FAIL);
    chk(st7[1], 1'b1, "request bit");
    rnd(MODE_FAIL);
    @(posedge clk) req <= 0;
    wait_md(MODE_NORMAL);
    @(posedge clk) {rlow, wake, pwm, drv} <= {1'b0, 1'b1, 5'h1f, 1'b1};
    run(5);
    chk({cpo, cpoe}, 2'b10, "clock pin");
    @(posedge clk) sup <= 3'b011;
    run(5);
    chk(pch, 5'h00, "bat loss");
    chk(frep, flt, "bat loss faults");
    chk(ext, 1'b1, "bat loss driver");
    chk(cpoe, 1'b1, "bat loss wake");
    @(posedge clk) sup <= 3'b110;
    run(5);
    chk(pch, 5'h00, "ground loss");
    @(posedge clk) sup <= 3'b101;
    wait_md(MODE_FAIL);
    @(posedge clk) sup <= 3'b111;
    wait_md(MODE_NORMAL);
    @(posedge clk) sup <= 3'b001;
    wait_md(MODE_POWER_OFF);
    chk({pch, ext}, 6'h00, "power off outputs");
    chk(frep, 8'h00, "power off faults");
    chk(st7, 8'h00, "power off status");
    stop_test();
  end
endmodule

`default_nettype wire
